// ===== src/adf_cfg.svh
// constants for the output data formatter: addresses, fields, codes and patterns
`ifndef ADF_CFG_SVH
`define ADF_CFG_SVH

// ==========================================================
// serial frame layout
`define ADF_FRAME_BITS 5'h10
`define ADF_HEAD_BITS 5'h08
`define ADF_CNT_ZERO 5'h00
`define ADF_CNT_ONE 5'h01
`define ADF_RW_POS 15
`define ADF_ADDR_HI 14
`define ADF_ADDR_LO 8
`define ADF_HEAD_RW_POS 7
`define ADF_HEAD_ADDR_HI 6
`define ADF_HEAD_ADDR_LO 0
`define ADF_DATA_HI 7
`define ADF_DATA_LO 0
`define ADF_SHIFT_CLEAR 16'h0000
`define ADF_OUT_IDLE 8'hFF

// ==========================================================
// register addresses
`define ADF_RESET_ADDR 7'h00
`define ADF_FORMAT_ADDR 7'h04

// ==========================================================
// register fields and reset values
`define ADF_SWRST_BIT 7
`define ADF_TEST_HI 5
`define ADF_TEST_LO 3
`define ADF_ABP_BIT 2
`define ADF_OUTPUT_SCRAMBLE_ENABLE_BIT 1
`define ADF_TWOS_BIT 0
`define ADF_FORMAT_RESET 8'h00
`define ADF_READ_NONE 8'h00

// ==========================================================
// test select codes
`define ADF_TEST_OFF 3'h0
`define ADF_TEST_ZERO 3'h1
`define ADF_TEST_ONE 3'h3
`define ADF_TEST_CHECKER 3'h5
`define ADF_TEST_ALTERNATE 3'h7

// ==========================================================
// sample layout and fixed output words, overflow flag in the top bit
`define ADF_SAMPLE_MSB 11
`define ADF_WORD_ZERO 13'h0000
`define ADF_WORD_ONE 13'h1FFF
`define ADF_CHECKER_A 13'h1555
`define ADF_CHECKER_B 13'h0AAA
`define ADF_ODD_MASK 12'hAAA
`define ADF_SAMPLE_ZERO 12'h000

`endif

// ===== src/adf_pkg.sv
// types shared by the output data formatter
package adf_pkg;

	// ==========================================================
	// serial port states, one-hot
	typedef enum logic [2:0] {
		ADF_SER_IDLE = 3'b001,
		ADF_SER_SHIFT = 3'b010,
		ADF_SER_DONE = 3'b100
	} adf_ser_state_e;

	// three-bit test select code
	typedef logic [2:0] adf_test_t;

	// overflow flag plus twelve sample bits
	typedef logic [12:0] adf_word_t;

endpackage

// ===== src/adf_sync.sv
// two flip-flop synchroniser for one pin input
`timescale 1ns/1ps

module adf_sync #(
	parameter logic RST_VAL = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// pin side and synchronised side
	input wire logic pin_in,
	output logic sync_out
);

	// first stage, read only by the second stage
	logic meta_reg;
	// second stage, safe for logic to read
	logic stable_reg;

	// two registers in series, reset to the idle level of the pin
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_reg <= RST_VAL;
			stable_reg <= RST_VAL;
		end else begin
			meta_reg <= pin_in;
			stable_reg <= meta_reg;
		end
	end

	assign sync_out = stable_reg;

endmodule

// ===== src/adf_formatter.sv
// output data formatter with its serial configuration port
`timescale 1ns/1ps
`include "adf_cfg.svh"

module adf_formatter import adf_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// serial configuration pins
	input wire logic cs_b,
	input wire logic sck,
	input wire logic sdi,
	output logic sdo_o,
	output logic sdo_oe,
	// converted samples, offset binary, from the conversion core
	input wire logic conv_valid,
	input wire logic [11:0] conv_sample,
	input wire logic conv_overflow,
	// formatted samples toward the capture logic
	output logic out_valid,
	output logic [11:0] sample_bits,
	output logic overflow_flag
);

	// ==========================================================
	// pin synchronisers

	// synchronised chip select, low during a frame
	logic cs_b_s;
	// synchronised serial clock
	logic sck_s;
	// synchronised serial data in
	logic sdi_s;

	// chip select idles high
	adf_sync #(.RST_VAL(1'b1)) u_sync_cs (
		.clk(clk),
		.rst_b(rst_b),
		.pin_in(cs_b),
		.sync_out(cs_b_s)
	);

	// serial clock idles low
	adf_sync #(.RST_VAL(1'b0)) u_sync_sck (
		.clk(clk),
		.rst_b(rst_b),
		.pin_in(sck),
		.sync_out(sck_s)
	);

	// serial data has no idle level of its own
	adf_sync #(.RST_VAL(1'b0)) u_sync_sdi (
		.clk(clk),
		.rst_b(rst_b),
		.pin_in(sdi),
		.sync_out(sdi_s)
	);

	// ==========================================================
	// serial clock edge detection

	// previous synchronised serial clock
	logic sck_d_reg;
	// one-cycle pulses on each serial clock edge
	logic sck_rise;
	logic sck_fall;

	// delayed copy for the edge compare
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sck_d_reg <= 1'b0;
		end else begin
			sck_d_reg <= sck_s;
		end
	end

	assign sck_rise = sck_s & ~sck_d_reg;
	assign sck_fall = ~sck_s & sck_d_reg;

	// ==========================================================
	// serial port state

	// frame state
	adf_ser_state_e ser_state_reg;
	adf_ser_state_e ser_state_next;
	// rising edges taken so far in this frame
	logic [4:0] bit_cnt_reg;
	logic [4:0] bit_cnt_next;
	// incoming frame bits, first bit ends up on top
	logic [15:0] shift_in_reg;
	logic [15:0] shift_in_next;
	// read data being sent, top bit on the pin
	logic [7:0] shift_out_reg;
	logic [7:0] shift_out_next;
	// read header seen, data goes out after next falling edge
	logic rd_pend_reg;
	logic rd_pend_next;
	// read data is on the pin
	logic sdo_active_reg;
	logic sdo_active_next;
	// data format control register
	logic [7:0] output_data_format_control_reg;
	logic [7:0] output_data_format_control_next;

	// frame with the current bit shifted in
	logic [15:0] shifted;
	// register contents for the addressed read
	logic [7:0] read_data;
	// count after this rising edge
	logic [4:0] cnt_inc;

	assign shifted = {shift_in_reg[14:0], sdi_s};
	assign cnt_inc = bit_cnt_reg + `ADF_CNT_ONE;

	// read decode on the header address; other addresses read zero
	always_comb begin
		if (shifted[`ADF_HEAD_ADDR_HI:`ADF_HEAD_ADDR_LO] == `ADF_FORMAT_ADDR) begin
			read_data = output_data_format_control_reg;
		end else begin
			read_data = `ADF_READ_NONE;
		end
	end

	// next-state logic for the serial port and the register
	always_comb begin
		ser_state_next = ser_state_reg;
		bit_cnt_next = bit_cnt_reg;
		shift_in_next = shift_in_reg;
		shift_out_next = shift_out_reg;
		rd_pend_next = rd_pend_reg;
		sdo_active_next = sdo_active_reg;
		output_data_format_control_next = output_data_format_control_reg;
		case (ser_state_reg)
			ADF_SER_IDLE: begin
				// chip select low opens a frame
				if (!cs_b_s) begin
					ser_state_next = ADF_SER_SHIFT;
					bit_cnt_next = `ADF_CNT_ZERO;
					shift_in_next = `ADF_SHIFT_CLEAR;
				end
			end
			ADF_SER_SHIFT: begin
				if (cs_b_s) begin
					// frame cut short: nothing is written
					ser_state_next = ADF_SER_IDLE;
				end else if (sck_rise) begin
					// take one bit on each rising edge
					shift_in_next = shifted;
					bit_cnt_next = cnt_inc;
					// header complete with read flag high: arm read data
					if (cnt_inc == `ADF_HEAD_BITS && shifted[`ADF_HEAD_RW_POS]) begin
						rd_pend_next = 1'b1;
						shift_out_next = read_data;
					end
					// sixteenth edge: frame complete, later edges ignored
					if (cnt_inc == `ADF_FRAME_BITS) begin
						ser_state_next = ADF_SER_DONE;
						// write only when the read flag is low
						if (!shifted[`ADF_RW_POS]) begin
							if (shifted[`ADF_ADDR_HI:`ADF_ADDR_LO] == `ADF_FORMAT_ADDR) begin
								// all eight bits stored, top two unused
								output_data_format_control_next =
									shifted[`ADF_DATA_HI:`ADF_DATA_LO];
							end else if (shifted[`ADF_ADDR_HI:`ADF_ADDR_LO] ==
								`ADF_RESET_ADDR && shifted[`ADF_SWRST_BIT]) begin
								// software reset, the bit itself is not kept
								output_data_format_control_next = `ADF_FORMAT_RESET;
							end
						end
					end
				end
			end
			ADF_SER_DONE: begin
				// wait for chip select to rise
				if (cs_b_s) begin
					ser_state_next = ADF_SER_IDLE;
				end
			end
			default: begin
				ser_state_next = ADF_SER_IDLE;
			end
		endcase
		// read data moves on falling edges, first one presents the top bit
		if (sck_fall && rd_pend_reg) begin
			rd_pend_next = 1'b0;
			sdo_active_next = 1'b1;
		end else if (sck_fall && sdo_active_reg) begin
			// ones fill behind, so the pin is released after the last bit
			shift_out_next = {shift_out_reg[6:0], 1'b1};
		end
		// chip select high ends any read
		if (cs_b_s) begin
			rd_pend_next = 1'b0;
			sdo_active_next = 1'b0;
		end
	end

	// serial port registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ser_state_reg <= ADF_SER_IDLE;
			bit_cnt_reg <= `ADF_CNT_ZERO;
			shift_in_reg <= `ADF_SHIFT_CLEAR;
			shift_out_reg <= `ADF_OUT_IDLE;
			rd_pend_reg <= 1'b0;
			sdo_active_reg <= 1'b0;
			output_data_format_control_reg <= `ADF_FORMAT_RESET;
		end else begin
			ser_state_reg <= ser_state_next;
			bit_cnt_reg <= bit_cnt_next;
			shift_in_reg <= shift_in_next;
			shift_out_reg <= shift_out_next;
			rd_pend_reg <= rd_pend_next;
			sdo_active_reg <= sdo_active_next;
			output_data_format_control_reg <= output_data_format_control_next;
		end
	end

	// open drain: only ever pulls low
	assign sdo_o = 1'b0;
	assign sdo_oe = sdo_active_reg & ~shift_out_reg[7];

	// ==========================================================
	// format fields

	// test select code
	adf_test_t output_test_select;
	// alternate bit polarity
	logic alternate_polarity_enable;
	// randomizer
	logic output_scramble_enable;
	// two's complement coding
	logic signed_format_select;

	assign output_test_select = output_data_format_control_reg[`ADF_TEST_HI:`ADF_TEST_LO];
	assign alternate_polarity_enable = output_data_format_control_reg[`ADF_ABP_BIT];
	assign output_scramble_enable = output_data_format_control_reg[`ADF_OUTPUT_SCRAMBLE_ENABLE_BIT];
	assign signed_format_select = output_data_format_control_reg[`ADF_TWOS_BIT];

	// ==========================================================
	// sample datapath

	// pattern phase, flips on each sample
	logic phase_reg;
	logic phase_next;
	// registered outputs
	logic out_valid_reg;
	logic out_valid_next;
	adf_word_t word_reg;
	adf_word_t word_next;
	// sample after coding, scrambling and polarity
	logic [11:0] coded;
	// word chosen for this sample
	adf_word_t formatted;

	// transforms applied to live data
	always_comb begin
		coded = conv_sample;
		// two's complement flips the sign bit, unless polarity mode forces offset binary
		if (signed_format_select && !alternate_polarity_enable) begin
			coded[`ADF_SAMPLE_MSB] = ~coded[`ADF_SAMPLE_MSB];
		end
		// upper bits xor with the lowest bit, receiver undoes it the same way
		if (output_scramble_enable) begin
			coded[11:1] = coded[11:1] ^ {11{coded[0]}};
		end
		// alternate polarity inverts the odd-numbered bits
		if (alternate_polarity_enable) begin
			coded = coded ^ `ADF_ODD_MASK;
		end
	end

	// test pattern selection, a pattern wins over every transform
	always_comb begin
		case (output_test_select)
			`ADF_TEST_OFF: begin
				formatted = {conv_overflow, coded};
			end
			`ADF_TEST_ZERO: begin
				formatted = `ADF_WORD_ZERO;
			end
			`ADF_TEST_ONE: begin
				formatted = `ADF_WORD_ONE;
			end
			`ADF_TEST_CHECKER: begin
				formatted = phase_reg ? `ADF_CHECKER_B : `ADF_CHECKER_A;
			end
			`ADF_TEST_ALTERNATE: begin
				formatted = phase_reg ? `ADF_WORD_ONE : `ADF_WORD_ZERO;
			end
			default: begin
				// unused codes fall back to live data
				formatted = {conv_overflow, coded};
			end
		endcase
	end

	// next values for the output stage
	always_comb begin
		out_valid_next = conv_valid;
		phase_next = phase_reg;
		word_next = word_reg;
		if (conv_valid) begin
			word_next = formatted;
			phase_next = ~phase_reg;
		end
	end

	// output stage registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			out_valid_reg <= 1'b0;
			phase_reg <= 1'b0;
			word_reg <= `ADF_WORD_ZERO;
		end else begin
			out_valid_reg <= out_valid_next;
			phase_reg <= phase_next;
			word_reg <= word_next;
		end
	end

	// outputs straight from flip-flops
	assign out_valid = out_valid_reg;
	assign overflow_flag = word_reg[12];
	assign sample_bits = word_reg[11:0];

endmodule

// ===== tb/adf_formatter_props.sv
// port-level checks on the output data formatter
`timescale 1ns/1ps

module adf_formatter_props (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// serial pins
	input wire logic cs_b,
	input wire logic sck,
	input wire logic sdi,
	input wire logic sdo_o,
	input wire logic sdo_oe,
	// sample path
	input wire logic conv_valid,
	input wire logic [11:0] conv_sample,
	input wire logic conv_overflow,
	input wire logic out_valid,
	input wire logic [11:0] sample_bits,
	input wire logic overflow_flag
);
	// ==========================================================
	// one clock domain for every check
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	// each strobe gives an output strobe one cycle later
	valid_latency_a: assert property (conv_valid |=> out_valid)
		else $error("output strobe missing after sample strobe");
	// no strobe out without one in
	no_spurious_valid_a: assert property (!conv_valid |=> !out_valid)
		else $error("output strobe without sample strobe");
	// the word holds between samples
	word_hold_a: assert property (!conv_valid |=> $stable({overflow_flag, sample_bits}))
		else $error("output word changed without a sample");
	// back-to-back samples give back-to-back strobes
	burst_valid_a: assert property (conv_valid ##1 conv_valid |-> out_valid [*2])
		else $error("back to back strobes lost");
	// outputs come out of reset cleared
	reset_quiet_a: assert property ($rose(rst_b) |-> !out_valid && !overflow_flag
		&& sample_bits == 12'h000 && !sdo_oe)
		else $error("outputs not cleared after reset");
	// serial output released while deselected
	sdo_idle_a: assert property (cs_b [*6] |-> !sdo_oe)
		else $error("serial output driven while deselected");
	// open drain only pulls low
	sdo_low_only_a: assert property (sdo_o == 1'b0)
		else $error("serial output drives high");
	// read bits start only after a falling serial clock inside a frame
	sdo_start_a: assert property ($rose(sdo_oe) |-> !cs_b && !$past(cs_b, 4)
		&& !$past(sck, 3))
		else $error("serial output started outside a read");
endmodule

bind adf_formatter adf_formatter_props chk (.clk(clk), .rst_b(rst_b), .cs_b(cs_b),
	.sck(sck), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .conv_valid(conv_valid),
	.conv_sample(conv_sample), .conv_overflow(conv_overflow), .out_valid(out_valid),
	.sample_bits(sample_bits), .overflow_flag(overflow_flag));

// ===== tb/adf_capture.sv
// capture logic model that records formatted samples
`timescale 1ns/1ps

module adf_capture (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// formatted samples
	input wire logic out_valid,
	input wire logic [11:0] sample_bits,
	input wire logic overflow_flag,
	// recorded results
	output logic [12:0] last_word,
	output int count
);
	// take each word on its strobe edge, as a pin register would
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			last_word <= 13'h0000;
			count <= 0;
		end else if (out_valid) begin
			last_word <= {overflow_flag, sample_bits};
			count <= count + 1;
		end
	end
endmodule

// ===== tb/tb.sv
// self-checking bench for the output data formatter
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
	$display("[FAIL] %s expected %h seen %h", n, e, g); end end

module tb import adf_pkg::*;;
	// ==========================================================
	// stimulus and observed signals
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic cs_b = 1'b1;
	logic sck = 1'b0;
	logic sdi = 1'b0;
	logic conv_valid = 1'b0;
	logic conv_overflow = 1'b0;
	logic [11:0] conv_sample = 12'h000;
	wire sdo_o, sdo_oe, out_valid, overflow_flag;
	wire [11:0] sample_bits;
	wire [12:0] cap_word;
	int cap_count;
	wire sdo_line = sdo_oe ? sdo_o : 1'b1; // pull-up when released
	int miscompares = 0;
	int checked = 0;
	int sent = 0;
	int k;
	logic ph = 1'b0; // pattern phase, toggles every sample
	logic [7:0] rd;
	logic [7:0] cfgs [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07,
		8'h08, 8'h18, 8'h28, 8'h38, 8'h3F};

	adf_formatter uut (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .sck(sck), .sdi(sdi),
		.sdo_o(sdo_o), .sdo_oe(sdo_oe), .conv_valid(conv_valid), .conv_sample(conv_sample),
		.conv_overflow(conv_overflow), .out_valid(out_valid), .sample_bits(sample_bits),
		.overflow_flag(overflow_flag));
	adf_capture cap (.clk(clk), .rst_b(rst_b), .out_valid(out_valid),
		.sample_bits(sample_bits), .overflow_flag(overflow_flag), .last_word(cap_word),
		.count(cap_count));

	// 250 MHz clock
	initial begin
		forever #2 clk = ~clk;
	end

	// expected word: pattern first, else coding, scramble, polarity
	function automatic adf_word_t expw(logic [7:0] c, logic [11:0] s, logic ov, logic p);
		logic [11:0] d;
		d = s;
		case (c[5:3])
			3'h1: return 13'h0000;
			3'h3: return 13'h1FFF;
			3'h5: return p ? 13'h0AAA : 13'h1555;
			3'h7: return p ? 13'h1FFF : 13'h0000;
			default: ;
		endcase
		if (c[0] && !c[2]) d[11] = ~d[11];
		if (c[1]) d[11:1] = d[11:1] ^ {11{d[0]}};
		if (c[2]) d = d ^ 12'hAAA;
		return {ov, d};
	endfunction

	// one serial frame of nb bits, read bits sampled before each rise
	task spi(input logic rw, input logic [6:0] a, input logic [7:0] d, input int nb,
		output logic [7:0] r);
		logic [15:0] w;
		int i;
		w = {rw, a, d};
		r = 8'h00;
		@(negedge clk) cs_b = 1'b0;
		repeat (4) @(negedge clk);
		for (i = 0; i < nb; i++) begin
			sdi = w[15 - i];
			repeat (8) @(negedge clk);
			if (i >= 8) r = {r[6:0], sdo_line};
			sck = 1'b1;
			repeat (8) @(negedge clk);
			sck = 1'b0;
		end
		repeat (8) @(negedge clk);
		cs_b = 1'b1;
		repeat (6) @(negedge clk);
	endtask

	// two back-to-back samples, each checked the cycle after
	task burst(input logic [7:0] c, input logic [11:0] s, input logic ov);
		adf_word_t e;
		adf_word_t last;
		int i;
		last = 13'h0000;
		for (i = 0; i < 3; i++) begin
			@(negedge clk);
			if (i > 0) begin
				`CHK("word", e, {overflow_flag, sample_bits})
				last = e;
				ph = ~ph;
			end
			e = expw(c, s, ov, ph);
			conv_valid = (i < 2);
			conv_sample = s;
			conv_overflow = ov;
		end
		// the capture model takes the second word on the edge after its strobe
		@(negedge clk);
		`CHK("captured word", last, cap_word)
		sent += 2;
	endtask

	// counts and verdict
	task wrap_up;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// hang guard
	initial begin
		#100000;
		miscompares++;
		wrap_up();
	end

	// main sequence
	initial begin
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		`CHK("reset word", 13'h0000, {overflow_flag, sample_bits})
		spi(1'b0, 7'h00, 8'h80, 16, rd);
		spi(1'b1, 7'h04, 8'h00, 16, rd);
		`CHK("reset fmt", 8'h00, rd)
		$display("test reset done");
		spi(1'b0, 7'h04, 8'hC0, 16, rd);
		spi(1'b1, 7'h04, 8'h3F, 16, rd);
		`CHK("fmt readback", 8'hC0, rd)
		burst(8'hC0, 12'h123, 1'b1);
		spi(1'b1, 7'h04, 8'h00, 16, rd);
		`CHK("read no write", 8'hC0, rd)
		spi(1'b0, 7'h05, 8'h3F, 16, rd);
		spi(1'b1, 7'h05, 8'h00, 16, rd);
		`CHK("unmapped", 8'h00, rd)
		spi(1'b0, 7'h04, 8'h2A, 10, rd);
		spi(1'b1, 7'h04, 8'h00, 16, rd);
		`CHK("aborted frame", 8'hC0, rd)
		$display("test access done");
		// only the five defined test codes are ever written
		for (k = 0; k < 12; k++) begin
			spi(1'b0, 7'h04, cfgs[k], 16, rd);
			burst(cfgs[k], 12'hA5C, 1'b1);
			burst(cfgs[k], 12'h3B1, 1'b0);
		end
		$display("test format done");
		spi(1'b0, 7'h00, 8'h80, 16, rd);
		spi(1'b1, 7'h04, 8'h00, 16, rd);
		`CHK("soft reset", 8'h00, rd)
		burst(8'h00, 12'h801, 1'b0);
		$display("test soft reset done");
		repeat (2) @(negedge clk);
		`CHK("capture count", sent, cap_count)
		wrap_up();
	end
endmodule
